// ===== rtl/pars_cfg.svh
/*
  Constants of the pixel array readout sequencer: register offsets, field
  positions, reset values and timing counts. Assumes a 40 MHz hclk.
*/
`ifndef PARS_CFG_SVH
`define PARS_CFG_SVH

`define PARS_CLK_NS 25
`define PARS_GLB_RST_NS 1000
`define PARS_GLB_RST_CYC ((`PARS_GLB_RST_NS + `PARS_CLK_NS - 1) / `PARS_CLK_NS)

`define PARS_OFS_CTRL 8'h00
`define PARS_OFS_XS 8'h04
`define PARS_OFS_XE 8'h08
`define PARS_OFS_YS 8'h0c
`define PARS_OFS_YE 8'h10
`define PARS_OFS_ODD 8'h14
`define PARS_OFS_OSIZE 8'h18
`define PARS_OFS_EXP 8'h1c
`define PARS_OFS_LLEN 8'h20
`define PARS_OFS_STAT 8'h24

`define PARS_CTRL_EN 0
`define PARS_CTRL_MODE 1
`define PARS_CTRL_GO 2
`define PARS_CTRL_MIR 3
`define PARS_CTRL_FLIP 4
`define PARS_ODD_Y_LSB 4
`define PARS_OSIZE_Y_LSB 16

`define PARS_RST_XS 12'h008
`define PARS_RST_XE 12'hcc7
`define PARS_RST_YS 12'h008
`define PARS_RST_YE 12'h997
`define PARS_RST_XSZ 12'hcc0
`define PARS_RST_YSZ 12'h990
`define PARS_RST_ODD 3'h1
`define PARS_RST_EXP 12'h010
`define PARS_RST_LLEN 16'h0e10
`define PARS_RST_MIR 1'b1

`endif

// ===== rtl/pars_pkg.sv
/*
  Types of the pixel array readout sequencer.
  Assumes pars_cfg.svh holds the numeric constants.
*/
package pars_pkg;
  typedef enum logic [2:0] {
    PARS_IDLE, PARS_FRAME, PARS_GLB_RST, PARS_GLB_EXP, PARS_GLB_READ
  } pars_state_e;
  typedef logic [11:0] pars_addr_t;
endpackage

// ===== rtl/pars_top.sv
/*
  Row and column address sequencer with AHB-Lite register slave.
  Assumes one 40 MHz clock shared with the bus and the array drivers.
*/
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pars_cfg.svh"
module pars_top import pars_pkg::*; #(
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [11:0] row_rst_addr,
  output logic row_rst_stb,
  output logic [11:0] row_rd_addr,
  output logic row_rd_stb,
  output logic [11:0] col_addr,
  output logic col_valid,
  output logic frame_start,
  output logic glob_rst,
  output logic shutter_open
);
  if (AW != 12) begin : g_chk
    $error("pars_top supports only 12-bit array addresses");
  end

  function automatic pars_addr_t step(pars_addr_t a, logic [2:0] odd, logic rev);
    if (!rev) begin
      step = a[0] ? a + 12'(odd) : a + 12'h001;
    end else begin
      step = a[0] ? a - 12'h001 : a - 12'(odd);
    end
  endfunction

  function automatic logic [12:0] count(pars_addr_t s, pars_addr_t e, logic [2:0] odd);
    logic [12:0] span;
    span = {1'b0, e} - {1'b0, s} + 13'(odd);
    count = (odd == 3'h7) ? span >> 2 : (odd == 3'h3) ? span >> 1 : span;
  endfunction

  pars_state_e st_r, st_nxt;
  logic en_r, en_nxt, mode_r, mode_nxt, go_r, go_nxt, mir_r, mir_nxt, flip_r, flip_nxt;
  pars_addr_t xs_r, xs_nxt, xe_r, xe_nxt, ys_r, ys_nxt, ye_r, ye_nxt;
  pars_addr_t xsz_r, xsz_nxt, ysz_r, ysz_nxt, exp_r, exp_nxt;
  logic [2:0] xodd_r, xodd_nxt, yodd_r, yodd_nxt;
  logic [15:0] llen_r, llen_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic wpend_r, wpend_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic mir_f, mir_f_nxt, flip_f, flip_f_nxt;
  pars_addr_t xs_f, xs_f_nxt, xe_f, xe_f_nxt, ys_f, ys_f_nxt, ye_f, ye_f_nxt;
  logic [2:0] xodd_f, xodd_f_nxt, yodd_f, yodd_f_nxt;
  logic [12:0] ncol_f, ncol_f_nxt, nrows_f, nrows_f_nxt, nrd_f, nrd_f_nxt;
  logic [12:0] exp_f, exp_f_nxt, col_left_r, col_left_nxt;
  logic [15:0] llen_f, llen_f_nxt, tmr_r, tmr_nxt;
  logic [13:0] line_r, line_nxt;
  pars_addr_t rst_ptr_r, rst_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  pars_addr_t rra_r, rra_nxt, rda_r, rda_nxt, ca_r, ca_nxt;
  logic rrs_r, rrs_nxt, rds_r, rds_nxt, cv_r, cv_nxt, fs_r, fs_nxt;
  logic gr_r, gr_nxt, sh_r, sh_nxt;
  logic rdy_r, resp_r;

  always_comb begin
    logic ap, ld, tmr_end, seq;
    logic [13:0] rd_line;
    logic [12:0] nc, nr, ny;
    ap = hsel && htrans[1] && hready;
    ld = 1'b0;
    tmr_end = (tmr_r == llen_f - 16'h1);
    seq = (st_r == PARS_FRAME) || (st_r == PARS_GLB_READ);
    rd_line = line_r - {1'b0, exp_f};
    nc = count(xs_r, xe_r, xodd_r);
    nr = count(ys_r, ye_r, yodd_r);
    ny = {1'b0, ysz_r};
    st_nxt = st_r;
    {en_nxt, mode_nxt, mir_nxt, flip_nxt} = {en_r, mode_r, mir_r, flip_r};
    go_nxt = 1'b0;
    {xs_nxt, xe_nxt, ys_nxt, ye_nxt} = {xs_r, xe_r, ys_r, ye_r};
    {xsz_nxt, ysz_nxt, exp_nxt} = {xsz_r, ysz_r, exp_r};
    {xodd_nxt, yodd_nxt, llen_nxt} = {xodd_r, yodd_r, llen_r};
    phase_nxt = {flip_r, mir_r};
    wpend_nxt = ap && hwrite;
    wa_nxt = ap ? haddr[7:0] : wa_r;
    rdata_nxt = rdata_r;
    if (ap && !hwrite) begin
      case (haddr[7:0])
        `PARS_OFS_CTRL: rdata_nxt = {27'h0, flip_r, mir_r, 1'b0, mode_r, en_r};
        `PARS_OFS_XS: rdata_nxt = {20'h0, xs_r};
        `PARS_OFS_XE: rdata_nxt = {20'h0, xe_r};
        `PARS_OFS_YS: rdata_nxt = {20'h0, ys_r};
        `PARS_OFS_YE: rdata_nxt = {20'h0, ye_r};
        `PARS_OFS_ODD: rdata_nxt = {25'h0, yodd_r, 1'b0, xodd_r};
        `PARS_OFS_OSIZE: rdata_nxt = {4'h0, ysz_r, 4'h0, xsz_r};
        `PARS_OFS_EXP: rdata_nxt = {20'h0, exp_r};
        `PARS_OFS_LLEN: rdata_nxt = {16'h0, llen_r};
        `PARS_OFS_STAT: rdata_nxt = {25'h0, 3'(st_r), sh_r, gr_r, phase_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    if (wpend_r) begin
      case (wa_r)
        `PARS_OFS_CTRL: begin
          en_nxt = hwdata[`PARS_CTRL_EN];
          mode_nxt = hwdata[`PARS_CTRL_MODE];
          go_nxt = hwdata[`PARS_CTRL_GO];
          mir_nxt = hwdata[`PARS_CTRL_MIR];
          flip_nxt = hwdata[`PARS_CTRL_FLIP];
        end
        `PARS_OFS_XS: xs_nxt = hwdata[11:0];
        `PARS_OFS_XE: xe_nxt = hwdata[11:0];
        `PARS_OFS_YS: ys_nxt = hwdata[11:0];
        `PARS_OFS_YE: ye_nxt = hwdata[11:0];
        `PARS_OFS_ODD: begin
          // other step values would break the pair pattern, so they are dropped
          if (hwdata[2:0] inside {3'h1, 3'h3, 3'h7}) xodd_nxt = hwdata[2:0];
          if (hwdata[6:4] inside {3'h1, 3'h3, 3'h7}) yodd_nxt = hwdata[6:4];
        end
        `PARS_OFS_OSIZE: begin
          xsz_nxt = hwdata[11:0];
          ysz_nxt = hwdata[`PARS_OSIZE_Y_LSB +: 12];
        end
        `PARS_OFS_EXP: exp_nxt = hwdata[11:0];
        `PARS_OFS_LLEN: if (hwdata[15:0] != 16'h0) llen_nxt = hwdata[15:0];
        default: ;
      endcase
    end

    // frame snapshot: a frame never sees a half-applied setting
    {mir_f_nxt, flip_f_nxt} = {mir_f, flip_f};
    {xs_f_nxt, xe_f_nxt, ys_f_nxt, ye_f_nxt} = {xs_f, xe_f, ys_f, ye_f};
    {xodd_f_nxt, yodd_f_nxt} = {xodd_f, yodd_f};
    {ncol_f_nxt, nrows_f_nxt, nrd_f_nxt, exp_f_nxt} = {ncol_f, nrows_f, nrd_f, exp_f};
    {llen_f_nxt, tmr_nxt, line_nxt} = {llen_f, tmr_r, line_r};
    {rst_ptr_nxt, rd_ptr_nxt} = {rst_ptr_r, rd_ptr_r};
    {rra_nxt, rda_nxt, ca_nxt, col_left_nxt} = {rra_r, rda_r, ca_r, col_left_r};
    {rrs_nxt, rds_nxt, fs_nxt, cv_nxt} = 4'h0;
    {gr_nxt, sh_nxt} = {gr_r, sh_r};

    if (col_left_r != 13'h0) begin
      cv_nxt = 1'b1;
      ca_nxt = step(ca_r, xodd_f, mir_f);
      col_left_nxt = col_left_r - 13'h1;
    end
    if (seq && tmr_r == 16'h0) begin
      if (st_r == PARS_FRAME && line_r < {1'b0, nrows_f}) begin
        rrs_nxt = 1'b1;
        rra_nxt = rst_ptr_r;
        rst_ptr_nxt = step(rst_ptr_r, yodd_f, flip_f);
      end
      if (line_r >= {1'b0, exp_f} && rd_line < {1'b0, nrd_f}) begin
        rds_nxt = 1'b1;
        rda_nxt = rd_ptr_r;
        rd_ptr_nxt = step(rd_ptr_r, yodd_f, flip_f);
        ca_nxt = mir_f ? xe_f : xs_f;
        cv_nxt = (ncol_f != 13'h0);
        col_left_nxt = (ncol_f != 13'h0) ? ncol_f - 13'h1 : 13'h0;
      end
    end
    if (st_r != PARS_IDLE) begin
      tmr_nxt = tmr_end ? 16'h0 : tmr_r + 16'h1;
      if (tmr_end) line_nxt = line_r + 14'h1;
    end

    case (st_r)
      PARS_IDLE: begin
        if (en_r && !mode_r) begin
          ld = 1'b1;
          st_nxt = PARS_FRAME;
        end else if (go_r && mode_r) begin
          ld = 1'b1;
          st_nxt = PARS_GLB_RST;
          gr_nxt = 1'b1;
          sh_nxt = 1'b1;
        end
      end
      PARS_FRAME: begin
        if (tmr_end && line_r == {1'b0, nrows_f} + {1'b0, exp_f} - 14'h1) begin
          if (en_r && !mode_r) begin
            ld = 1'b1;
          end else begin
            st_nxt = PARS_IDLE;
          end
        end
      end
      PARS_GLB_RST: begin
        // counts past the line length, so a short line cannot cut the reset pulse
        tmr_nxt = tmr_r + 16'h1;
        if (tmr_r == 16'(`PARS_GLB_RST_CYC - 1)) begin
          gr_nxt = 1'b0;
          st_nxt = PARS_GLB_EXP;
          tmr_nxt = 16'h0;
          line_nxt = 14'h0;
        end
      end
      PARS_GLB_EXP: begin
        if (tmr_end && line_r >= {1'b0, exp_f} - 14'h1) begin
          sh_nxt = 1'b0;
          st_nxt = PARS_GLB_READ;
          exp_f_nxt = 13'h0;
          line_nxt = 14'h0;
        end
      end
      PARS_GLB_READ: begin
        if (tmr_end && line_r == {1'b0, nrd_f} - 14'h1) st_nxt = PARS_IDLE;
      end
      default: st_nxt = PARS_IDLE;
    endcase

    if (ld) begin
      fs_nxt = 1'b1;
      tmr_nxt = 16'h0;
      line_nxt = 14'h0;
      mir_f_nxt = mir_r;
      flip_f_nxt = flip_r;
      xs_f_nxt = xs_r;
      xe_f_nxt = xe_r;
      ys_f_nxt = ys_r;
      ye_f_nxt = ye_r;
      xodd_f_nxt = xodd_r;
      yodd_f_nxt = yodd_r;
      ncol_f_nxt = (nc < {1'b0, xsz_r}) ? nc : {1'b0, xsz_r};
      nrows_f_nxt = nr;
      nrd_f_nxt = (nr < ny) ? nr : ny;
      exp_f_nxt = {1'b0, exp_r};
      llen_f_nxt = llen_r;
      rst_ptr_nxt = flip_r ? ye_r : ys_r;
      rd_ptr_nxt = flip_r ? ye_r : ys_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= PARS_IDLE;
      {en_r, mode_r, go_r, flip_r} <= 4'h0;
      mir_r <= `PARS_RST_MIR;
      xs_r <= `PARS_RST_XS;
      xe_r <= `PARS_RST_XE;
      ys_r <= `PARS_RST_YS;
      ye_r <= `PARS_RST_YE;
      xsz_r <= `PARS_RST_XSZ;
      ysz_r <= `PARS_RST_YSZ;
      exp_r <= `PARS_RST_EXP;
      xodd_r <= `PARS_RST_ODD;
      yodd_r <= `PARS_RST_ODD;
      llen_r <= `PARS_RST_LLEN;
      phase_r <= {1'b0, `PARS_RST_MIR};
      wpend_r <= 1'b0;
      wa_r <= 8'h0;
      rdata_r <= 32'h0;
      {mir_f, flip_f} <= 2'h0;
      {xs_f, xe_f, ys_f, ye_f} <= 48'h0;
      {xodd_f, yodd_f} <= {3'h1, 3'h1};
      {ncol_f, nrows_f, nrd_f, exp_f, col_left_r} <= 65'h0;
      llen_f <= 16'h1;
      tmr_r <= 16'h0;
      line_r <= 14'h0;
      {rst_ptr_r, rd_ptr_r, rra_r, rda_r, ca_r} <= 60'h0;
      {rrs_r, rds_r, cv_r, fs_r, gr_r, sh_r} <= 6'h0;
      {rdy_r, resp_r} <= 2'h2;
    end else begin
      st_r <= st_nxt;
      {en_r, mode_r, go_r, mir_r, flip_r} <= {en_nxt, mode_nxt, go_nxt, mir_nxt, flip_nxt};
      {xs_r, xe_r, ys_r, ye_r} <= {xs_nxt, xe_nxt, ys_nxt, ye_nxt};
      {xsz_r, ysz_r, exp_r} <= {xsz_nxt, ysz_nxt, exp_nxt};
      {xodd_r, yodd_r, llen_r, phase_r} <= {xodd_nxt, yodd_nxt, llen_nxt, phase_nxt};
      {wpend_r, wa_r, rdata_r} <= {wpend_nxt, wa_nxt, rdata_nxt};
      {mir_f, flip_f} <= {mir_f_nxt, flip_f_nxt};
      {xs_f, xe_f, ys_f, ye_f} <= {xs_f_nxt, xe_f_nxt, ys_f_nxt, ye_f_nxt};
      {xodd_f, yodd_f} <= {xodd_f_nxt, yodd_f_nxt};
      {ncol_f, nrows_f, nrd_f, exp_f} <= {ncol_f_nxt, nrows_f_nxt, nrd_f_nxt, exp_f_nxt};
      {col_left_r, llen_f, tmr_r, line_r} <= {col_left_nxt, llen_f_nxt, tmr_nxt, line_nxt};
      {rst_ptr_r, rd_ptr_r, rra_r, rda_r, ca_r} <=
        {rst_ptr_nxt, rd_ptr_nxt, rra_nxt, rda_nxt, ca_nxt};
      {rrs_r, rds_r, cv_r, fs_r, gr_r, sh_r} <= {rrs_nxt, rds_nxt, cv_nxt, fs_nxt, gr_nxt, sh_nxt};
      {rdy_r, resp_r} <= 2'h2;
    end
  end

  // zero-wait slave; hreadyout and hresp are constants held in flops
  assign hreadyout = rdy_r;
  assign hresp = resp_r;
  assign hrdata = rdata_r;
  assign {row_rst_addr, row_rst_stb, row_rd_addr, row_rd_stb} = {rra_r, rrs_r, rda_r, rds_r};
  assign {col_addr, col_valid, frame_start, glob_rst, shutter_open} = {ca_r, cv_r, fs_r, gr_r, sh_r};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence glb_release_s;
    (sh_r && st_r == PARS_GLB_EXP) ##1 (st_r inside {PARS_GLB_EXP, PARS_GLB_READ});
  endsequence

  col_first_a: assert property (rds_r && ncol_f != 13'h0 && !fs_r |->
    cv_r && ca_r == (mir_f ? xe_f : xs_f))
    else $error("first column of a line is not the window edge");
  col_step_a: assert property (cv_r && !mir_f && !ca_r[0] && col_left_r != 13'h0
    |=> ca_r == $past(ca_r) + 12'h001) else $error("column did not advance by one");
  odd_legal_a: assert property (xodd_r inside {3'h1, 3'h3, 3'h7} &&
    yodd_r inside {3'h1, 3'h3, 3'h7}) else $error("illegal odd step held");
  bayer_phase_a: assert property ($changed({flip_r, mir_r}) |=>
    phase_r == $past({flip_r, mir_r})) else $error("phase indicator stale");
  exp_uniform_a: assert property (st_r == PARS_FRAME && !fs_r |-> $stable(exp_f))
    else $error("exposure moved inside a frame");
  read_gap_a: assert property (rds_r && st_r == PARS_FRAME && !fs_r |->
    line_r >= {1'b0, exp_f}) else $error("row read before its exposure elapsed");
  skip_phase_a: assert property (cv_r && xodd_f == 3'h3 |-> ca_r[1] == xs_f[1])
    else $error("2x skip read a wrong column pair");
  col_window_a: assert property (cv_r |-> ca_r >= xs_f && ca_r <= xe_f)
    else $error("column outside programmed window");
  row_count_a: assert property (fs_r |-> nrows_f ==
    ({1'b0, ye_f} - {1'b0, ys_f} + 13'(yodd_f)) / 13'(({1'b0, yodd_f} + 4'h1) >> 1))
    else $error("row count differs from span over decimation");
  glb_order_a: assert property ($fell(gr_r) |-> glb_release_s)
    else $error("shutter not open after global reset release");
endmodule

// ===== test/pars_array_model.sv
/*
  Array-side model: records the row reset and row read strobes, the column
  addresses, frame starts and how long the global reset and shutter lines
  stay high.
  Assumes it shares the sequencer clock; the array is passive, it never answers.
*/
`timescale 1ns/1ps
module pars_array_model (
  input wire logic clk,
  input wire logic [11:0] rst_addr,
  input wire logic rst_stb,
  input wire logic [11:0] rd_addr,
  input wire logic rd_stb,
  input wire logic [11:0] col,
  input wire logic col_ok,
  input wire logic grst,
  input wire logic shut,
  input wire logic fstart
);
  logic [11:0] rows[$];
  logic [11:0] rsts[$];
  logic [11:0] cols[$];
  int rst_t[$];
  int rd_t[$];
  int cyc = 0;
  int grst_n = 0;
  int shut_n = 0;
  int fs_n = 0;
  // timestamps let the bench see the reset-to-read gap of every row
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rst_stb === 1'b1) begin
      rsts.push_back(rst_addr);
      rst_t.push_back(cyc);
    end
    if (rd_stb === 1'b1) begin
      rows.push_back(rd_addr);
      rd_t.push_back(cyc);
    end
    if (col_ok === 1'b1) begin
      cols.push_back(col);
    end
    if (grst === 1'b1) begin
      grst_n <= grst_n + 1;
    end
    if (shut === 1'b1) begin
      shut_n <= shut_n + 1;
    end
    if (fstart === 1'b1) begin
      fs_n <= fs_n + 1;
    end
  end
endmodule

// ===== test/tb_top.sv
/*
  Self-checking bench: AHB-Lite register tasks, then rolling and global
  reset captures checked against the array-side model's records.
  Assumes the single slave drives hready back through hreadyout.
*/
`timescale 1ns/1ps
`include "pars_cfg.svh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, rrs, rrd, cv, fs, gr, sh;
  logic [11:0] ra, rb, ca;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 hclk = ~hclk;
  pars_top pars_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .row_rst_addr(ra),
    .row_rst_stb(rrs), .row_rd_addr(rb), .row_rd_stb(rrd), .col_addr(ca), .col_valid(cv),
    .frame_start(fs), .glob_rst(gr), .shutter_open(sh));
  pars_array_model pars_array_model_inst (.clk(hclk), .rst_addr(ra), .rst_stb(rrs),
    .rd_addr(rb), .rd_stb(rrd), .col(ca), .col_ok(cv), .grst(gr), .shut(sh), .fstart(fs));

  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // entered and left just after a rising edge; one single word transfer
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin n_fail++; finish_test(); end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wait_rows(input int n);
    for (int i = 0; i < 5000; i++) begin
      if (pars_array_model_inst.rows.size() >= n) return;
      @(posedge hclk);
    end
    n_fail++;
    finish_test();
  endtask
  task automatic wait_idle;
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 2000; i++) begin
      ahb(`PARS_OFS_STAT, 1'b0, 32'h0);
      if (rd[6:4] === 3'h0) return;
    end
    n_fail++;
    finish_test();
  endtask
  task automatic clr;
    pars_array_model_inst.rows.delete();
    pars_array_model_inst.rsts.delete();
    pars_array_model_inst.cols.delete();
    pars_array_model_inst.rst_t.delete();
    pars_array_model_inst.rd_t.delete();
  endtask
  task automatic win(input logic [31:0] xe, input logic [31:0] ye, input logic [31:0] odd);
    ahb(`PARS_OFS_XS, 1'b1, 32'h0);
    ahb(`PARS_OFS_XE, 1'b1, xe);
    ahb(`PARS_OFS_YS, 1'b1, 32'h0);
    ahb(`PARS_OFS_YE, 1'b1, ye);
    ahb(`PARS_OFS_ODD, 1'b1, odd);
  endtask
  // k-th address of a subsampled run, pair stride s
  function automatic logic [31:0] seq(input int k, input int s);
    return 32'(k / 2 * s + k % 2);
  endfunction

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl", `PARS_OFS_CTRL, 32'h8);
    rdchk("xs", `PARS_OFS_XS, 32'h8);
    rdchk("xe", `PARS_OFS_XE, 32'hcc7);
    rdchk("ye", `PARS_OFS_YE, 32'h997);
    rdchk("osize", `PARS_OFS_OSIZE, 32'h09900cc0);
    rdchk("stat", `PARS_OFS_STAT, 32'h1);
    ahb(8'h28, 1'b1, 32'hffff);
    rdchk("unmapped", 8'h28, 32'h0);
    // 2x2 skip, exposure changed mid-frame
    win(32'h5, 32'h5, 32'h33);
    ahb(`PARS_OFS_ODD, 1'b1, 32'h55);
    rdchk("odd", `PARS_OFS_ODD, 32'h33);
    ahb(`PARS_OFS_OSIZE, 1'b1, 32'h00040004);
    ahb(`PARS_OFS_EXP, 1'b1, 32'h2);
    ahb(`PARS_OFS_LLEN, 1'b1, 32'h8);
    ahb(`PARS_OFS_LLEN, 1'b1, 32'h0);
    rdchk("llen", `PARS_OFS_LLEN, 32'h8);
    ahb(`PARS_OFS_CTRL, 1'b1, 32'h1);
    repeat (4) @(posedge hclk);
    ahb(`PARS_OFS_EXP, 1'b1, 32'h3);
    wait_rows(5);
    ahb(`PARS_OFS_CTRL, 1'b1, 32'h0);
    wait_idle();
    chk("nrows", 32'd8, pars_array_model_inst.rows.size());
    chk("ncols", 32'd32, pars_array_model_inst.cols.size());
    chk("frames", 32'd2, pars_array_model_inst.fs_n);
    for (int i = 0; i < 8; i++) begin
      chk("row", seq(i % 4, 4), pars_array_model_inst.rows[i]);
      chk("rstrow", seq(i % 4, 4), pars_array_model_inst.rsts[i]);
      chk("gap", (i < 4) ? 16 : 24, pars_array_model_inst.rd_t[i] - pars_array_model_inst.rst_t[i]);
    end
    for (int i = 0; i < 4; i++) chk("col", seq(i, 4), pars_array_model_inst.cols[i]);
    // 4x4 skip, both directions reversed
    clr();
    win(32'h9, 32'h9, 32'h77);
    ahb(`PARS_OFS_CTRL, 1'b1, 32'h19);
    repeat (4) @(posedge hclk);
    ahb(`PARS_OFS_CTRL, 1'b1, 32'h18);
    wait_idle();
    rdchk("stat", `PARS_OFS_STAT, 32'h3);
    chk("nrows", 32'd4, pars_array_model_inst.rows.size());
    for (int i = 0; i < 4; i++) begin
      chk("row", seq(3 - i, 8), pars_array_model_inst.rows[i]);
      chk("col", seq(3 - i, 8), pars_array_model_inst.cols[i]);
    end
    // single capture with mechanical shutter, no skipping
    clr();
    win(32'h3, 32'h3, 32'h11);
    ahb(`PARS_OFS_OSIZE, 1'b1, 32'h00030002);
    ahb(`PARS_OFS_CTRL, 1'b1, 32'h6);
    wait_idle();
    chk("glob", `PARS_GLB_RST_CYC, pars_array_model_inst.grst_n);
    chk("shut", `PARS_GLB_RST_CYC + 24, pars_array_model_inst.shut_n);
    chk("nrst", 32'd0, pars_array_model_inst.rsts.size());
    chk("nrows", 32'd3, pars_array_model_inst.rows.size());
    chk("ncols", 32'd6, pars_array_model_inst.cols.size());
    chk("frames", 32'd4, pars_array_model_inst.fs_n);
    for (int i = 0; i < 6; i++) chk("col", seq(i % 2, 2), pars_array_model_inst.cols[i]);
    rdchk("stat", `PARS_OFS_STAT, 32'h0);
    finish_test();
  end
endmodule
